/* uef_cfg.svh */
// constants of the enhanced flow-control block: register offsets, field positions, reset values
// assumes a 32-bit apb slave with byte addresses, one register per aligned word
`ifndef UEF_CFG_SVH
`define UEF_CFG_SVH

// register byte offsets
`define UEF_OFS_EFR      8'h00
`define UEF_OFS_CHARS    8'h04
`define UEF_OFS_ENH      8'h08
`define UEF_OFS_CTRL     8'h0C
`define UEF_OFS_STATUS   8'h10
`define UEF_OFS_MASK     8'h14
`define UEF_OFS_STATE    8'h18

// reset values
`define UEF_RST_EFR      8'h00
`define UEF_RST_CHARS    32'h0000_0000
`define UEF_RST_ENH      11'h000
`define UEF_RST_CTRL     9'h000
`define UEF_RST_EVT      5'h00

// status / mask bit positions
`define UEF_EV_TRIG      0
`define UEF_EV_RESUME    1
`define UEF_EV_PAUSE     2
`define UEF_EV_CTS       3
`define UEF_EV_SPECIAL   4
`define UEF_EV_W         5

// control register fields
`define UEF_CTRL_RTS     0
`define UEF_CTRL_TRIG_LO 8
`define UEF_CTRL_TRIG_HI 15

// enhanced-field register width
`define UEF_ENH_W        11

// software flow-control codes
`define UEF_SW_NONE      2'b00
`define UEF_SW_PAIR2     2'b01
`define UEF_SW_PAIR1     2'b10
`define UEF_SW_BOTH      2'b11

// receive fill distance to the rts thresholds
`define UEF_LVL_STEP     9'h001
`define UEF_LVL_STEP2    9'h002

`endif

/* uef_pkg.sv */
// types shared by the enhanced flow-control block
// assumes uef_cfg.svh for numeric constants except the one-hot state codes given here
package uef_pkg;

  typedef struct packed {
    logic       auto_cts;
    logic       auto_rts;
    logic       special_det;
    logic       enhanced;
    logic [1:0] tx_sw;
    logic [1:0] rx_sw;
  } uef_efr_t;

  typedef struct packed {
    logic [7:0] pause_char_two;
    logic [7:0] pause_char_one;
    logic [7:0] resume_char_two;
    logic [7:0] resume_char_one;
  } uef_chars_t;

  typedef struct packed {
    logic [2:0] modem_control;
    logic [1:0] fifo_control;
    logic [1:0] interrupt_status;
    logic [3:0] interrupt_enable;
  } uef_enh_t;

  typedef enum logic [2:0] {
    UEF_FS_IDLE   = 3'b001,
    UEF_FS_FIRST  = 3'b010,
    UEF_FS_SECOND = 3'b100
  } uef_fs_t;

endpackage

/* uef_rx_match.sv */
// receive flow-character matcher: single, either-pair and two-character sequences
// assumes one received character per rx_valid pulse, synchronous to sys_clk
`include "uef_cfg.svh"

module uef_rx_match (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // setup
  input  wire logic [1:0]        tx_sw,
  input  wire logic [1:0]        rx_sw,
  input  wire uef_pkg::uef_chars_t chars,
  // received characters
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_data,
  // matches
  output logic                   resume_hit,
  output logic                   pause_hit
);

  logic r1, r2, p1, p2, seq_mode, either;
  logic prev_r1_q, prev_p1_q;

  // full byte compare, bit 0 against the lsb  see RULE_08
  assign r1 = rx_data == chars.resume_char_one;
  assign r2 = rx_data == chars.resume_char_two;
  assign p1 = rx_data == chars.pause_char_one;
  assign p2 = rx_data == chars.pause_char_two;

  // all four bits set asks for the two-character sequence  see RULE_15
  assign seq_mode = (rx_sw == `UEF_SW_BOTH) && (tx_sw == `UEF_SW_BOTH);
  assign either   = (rx_sw == `UEF_SW_BOTH) && !seq_mode;  // see RULE_14

  ////////////////////////////////////////////////////////////////////////////
  // first half of a pair remembered for one character only  see RULE_16
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prev_r1_q <= 1'b0;
      prev_p1_q <= 1'b0;
    end else if (rx_valid) begin
      prev_r1_q <= seq_mode && r1;
      prev_p1_q <= seq_mode && p1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    resume_hit = 1'b0;
    pause_hit  = 1'b0;
    if (rx_valid) begin
      if (seq_mode) begin
        resume_hit = prev_r1_q && r2;
        pause_hit  = prev_p1_q && p2;
      end else if (either) begin
        resume_hit = r1 || r2;
        pause_hit  = p1 || p2;
      end else if (rx_sw == `UEF_SW_PAIR1) begin  // see RULE_13
        resume_hit = r1;
        pause_hit  = p1;
      end else if (rx_sw == `UEF_SW_PAIR2) begin
        resume_hit = r2;
        pause_hit  = p2;
      end
    end
  end

endmodule

/* uef_ser_model.sv */
// serialiser stand-in: takes characters on ser_valid and ser_ready, logs them in order
// assumes the bench drives stall to hold the output stage of the block
module uef_ser_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // serialiser side
  input  wire logic       ser_valid,
  input  wire logic [7:0] ser_data,
  output logic            ser_ready,
  // bench control
  input  wire logic       stall
);
  logic [7:0]  log_q [0:63];
  int unsigned n_q;

  ////////////////////////////////////////
  // stalling shows whether the block holds its character
  assign ser_ready = ~stall;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      n_q <= 0;
    end else if (ser_valid && ser_ready) begin
      log_q[n_q[5:0]] <= ser_data;
      n_q             <= n_q + 1;
    end
  end
endmodule

/* uef_top.sv */
// enhanced flow control for one uart channel: apb registers, auto cts/rts, special char,
// software flow-control characters in the transmit path
// assumes a transmit queue ahead, a serialiser after, and a receiver reporting fill level
//
// Function
// RULE_01: auto cts set: stop sending on cts high
// RULE_02: auto cts: resume once cts low
// RULE_03: auto rts: interrupt at programmed trigger level
// RULE_04: auto rts: rts high one level above
// RULE_05: auto rts: rts low below level minus one
// RULE_06: auto rts off: rts follows software bit
// RULE_07: special detect: match pause two, flag bit 4
// RULE_08: character bit 0 compares received lsb
// RULE_09: software clears flow selection for special detect
// RULE_10: enhanced fields writable only while bit 4 set
// RULE_11: bit 4 set enables features, restores fields
// RULE_12: bits 3:2 select transmitted flow characters
// RULE_13: bits 1:0 select compared flow characters
// RULE_14: rx 11 with single tx: either pair
// RULE_15: all four set: two-character sequences both ways
// RULE_16: dual modes treat pair as sequence
// RULE_17: host avoids flow characters in payload
// RULE_18: matched pause halts transmit, resume continues
`include "uef_cfg.svh"

module uef_top (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // transmit data in
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  output logic             tx_ready,
  // to serialiser
  output logic             ser_valid,
  output logic [7:0]       ser_data,
  input  wire logic        ser_ready,
  // receive side
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic [7:0]  rx_level,
  // modem pins, logic level as on the pin
  input  wire logic        cts_in,
  output logic             rts_out,
  // enhanced fields to the rest of the channel
  output uef_pkg::uef_enh_t enh_fields,
  // interrupt
  output logic             irq
);

  uef_pkg::uef_efr_t   efr_q;
  uef_pkg::uef_chars_t chars_q;
  uef_pkg::uef_enh_t   enh_q;
  uef_pkg::uef_fs_t    fs_q;
  logic [8:0]          ctrl_q;
  logic [`UEF_EV_W-1:0] status_q, mask_q, ev;
  logic [31:0]         rdata_d, prdata_q;
  logic                wr, rd, setup, rts_auto_q, remote_paused_q, local_paused_q;
  logic                send_pause_q, cts_q, trig_q, cts_block, out_load, flow_start;
  logic                resume_hit, pause_hit, special_hit, at_trig, above_trig, below_trig;
  logic [8:0]          lvl9, trig9;

  ////////////////////////////////////////////////////////////////////////////
  // address decode, used for read and write
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `UEF_OFS_EFR, `UEF_OFS_CHARS, `UEF_OFS_ENH, `UEF_OFS_CTRL,
      `UEF_OFS_STATUS, `UEF_OFS_MASK, `UEF_OFS_STATE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // zero wait states: every access ends in its first access cycle
  assign setup   = psel && !penable;
  assign pready  = psel && penable;
  assign pslverr = pready && !mapped(paddr);
  assign wr      = pready && pwrite && mapped(paddr);
  assign rd      = pready && !pwrite;
  assign prdata  = prdata_q;

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `UEF_OFS_EFR:    rdata_d[7:0] = efr_q;
      `UEF_OFS_CHARS:  rdata_d = chars_q;
      `UEF_OFS_ENH:    rdata_d[`UEF_ENH_W-1:0] = enh_q;
      `UEF_OFS_CTRL:   rdata_d[`UEF_CTRL_TRIG_HI:0] = {ctrl_q[8:1], 7'h00, ctrl_q[0]};
      `UEF_OFS_STATUS: rdata_d[`UEF_EV_W-1:0] = status_q;
      `UEF_OFS_MASK:   rdata_d[`UEF_EV_W-1:0] = mask_q;
      `UEF_OFS_STATE:  rdata_d[15:0] = {rx_level, 5'h00, remote_paused_q, cts_block, rts_out};
      default:         rdata_d = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers; features all off after reset  see RULE_01 see RULE_06
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      efr_q   <= `UEF_RST_EFR;
      chars_q <= `UEF_RST_CHARS;
      ctrl_q  <= `UEF_RST_CTRL;
      mask_q  <= `UEF_RST_EVT;
    end else if (wr) begin
      case (paddr)
        `UEF_OFS_EFR:   efr_q   <= pwdata[7:0];  // see RULE_12 see RULE_13
        `UEF_OFS_CHARS: chars_q <= pwdata;
        `UEF_OFS_CTRL:  ctrl_q  <= {pwdata[`UEF_CTRL_TRIG_HI:`UEF_CTRL_TRIG_LO], pwdata[`UEF_CTRL_RTS]};
        `UEF_OFS_MASK:  mask_q  <= pwdata[`UEF_EV_W-1:0];
        default: ;
      endcase
    end
  end

  // enhanced fields: writes pass only while the enhanced bit is set, held otherwise;
  // the held copy survives clearing the bit, so setting it again brings it back
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      enh_q <= `UEF_RST_ENH;
    end else if (wr && paddr == `UEF_OFS_ENH && efr_q.enhanced) begin  // see RULE_10
      enh_q <= pwdata[`UEF_ENH_W-1:0];
    end
  end

  // fields only reach the channel while enhanced mode is on  see RULE_11
  assign enh_fields = efr_q.enhanced ? enh_q : `UEF_RST_ENH;

  ////////////////////////////////////////////////////////////////////////////
  // receive fill thresholds
  assign lvl9       = {1'b0, rx_level};
  assign trig9      = {1'b0, ctrl_q[8:1]};
  assign at_trig    = lvl9 >= trig9;
  assign above_trig = lvl9 >= trig9 + `UEF_LVL_STEP;   // see RULE_04
  assign below_trig = lvl9 + `UEF_LVL_STEP2 <= trig9;  // see RULE_05

  // hysteresis between the two thresholds keeps rts from chattering
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rts_auto_q <= 1'b0;
    end else if (!efr_q.auto_rts) begin
      rts_auto_q <= 1'b0;
    end else if (above_trig) begin
      rts_auto_q <= 1'b1;  // see RULE_04
    end else if (below_trig) begin
      rts_auto_q <= 1'b0;  // see RULE_05
    end
  end

  assign rts_out = efr_q.auto_rts ? rts_auto_q : ctrl_q[`UEF_CTRL_RTS];  // see RULE_06

  ////////////////////////////////////////////////////////////////////////////
  // receive character matching
  uef_rx_match u_match (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .tx_sw      (efr_q.tx_sw),
    .rx_sw      (efr_q.rx_sw),
    .chars      (chars_q),
    .rx_valid   (rx_valid),
    .rx_data    (rx_data),
    .resume_hit (resume_hit),
    .pause_hit  (pause_hit)
  );

  // character still goes to the fifo; only a flag is raised  see RULE_07 see RULE_08
  assign special_hit = efr_q.special_det && rx_valid && rx_data == chars_q.pause_char_two;

  // remote asked us to stop; resume wins nothing over a pause in the same cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      remote_paused_q <= 1'b0;
    end else if (efr_q.rx_sw == `UEF_SW_NONE) begin
      remote_paused_q <= 1'b0;
    end else if (pause_hit) begin
      remote_paused_q <= 1'b1;  // see RULE_18
    end else if (resume_hit) begin
      remote_paused_q <= 1'b0;  // see RULE_18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events, sticky status cleared by reading it; a new event beats the clear
  // only bits returned by the read are cleared, so an event at the setup edge survives
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trig_q <= 1'b0;
      cts_q  <= 1'b0;
    end else begin
      trig_q <= at_trig;
      cts_q  <= cts_in;
    end
  end

  assign ev[`UEF_EV_TRIG]    = efr_q.auto_rts && at_trig && !trig_q;  // see RULE_03
  assign ev[`UEF_EV_RESUME]  = resume_hit;
  assign ev[`UEF_EV_PAUSE]   = pause_hit;
  assign ev[`UEF_EV_CTS]     = cts_in != cts_q;
  assign ev[`UEF_EV_SPECIAL] = special_hit;  // see RULE_07

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      status_q <= `UEF_RST_EVT;
    end else if (rd && paddr == `UEF_OFS_STATUS) begin
      status_q <= (status_q & ~prdata_q[`UEF_EV_W-1:0]) | ev;
    end else begin
      status_q <= status_q | ev;
    end
  end

  assign irq = |(status_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // transmit path: flow characters take precedence over queued data
  assign cts_block = efr_q.auto_cts && cts_in;  // see RULE_01 see RULE_02
  assign out_load  = !ser_valid || ser_ready;
  assign flow_start = fs_q == uef_pkg::UEF_FS_IDLE && efr_q.tx_sw != `UEF_SW_NONE &&
                      ((above_trig && !local_paused_q) || (below_trig && local_paused_q));

  // a halt lets the character already in the output stage finish  see RULE_18
  assign tx_ready = fs_q == uef_pkg::UEF_FS_IDLE && !flow_start && !cts_block &&
                    !remote_paused_q && out_load;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fs_q           <= uef_pkg::UEF_FS_IDLE;
      send_pause_q   <= 1'b0;
      local_paused_q <= 1'b0;
    end else begin
      case (fs_q)
        uef_pkg::UEF_FS_IDLE: begin
          if (efr_q.tx_sw == `UEF_SW_NONE) begin
            local_paused_q <= 1'b0;
          end else if (flow_start) begin
            fs_q           <= uef_pkg::UEF_FS_FIRST;
            send_pause_q   <= !local_paused_q;
            local_paused_q <= !local_paused_q;
          end
        end
        uef_pkg::UEF_FS_FIRST: begin
          if (out_load && !cts_block) begin
            fs_q <= (efr_q.tx_sw == `UEF_SW_BOTH) ? uef_pkg::UEF_FS_SECOND : uef_pkg::UEF_FS_IDLE;
          end
        end
        uef_pkg::UEF_FS_SECOND: begin
          if (out_load && !cts_block) begin
            fs_q <= uef_pkg::UEF_FS_IDLE;
          end
        end
        default: fs_q <= uef_pkg::UEF_FS_IDLE;
      endcase
    end
  end

  // output stage towards the serialiser
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ser_valid <= 1'b0;
      ser_data  <= 8'h00;
    end else if (fs_q != uef_pkg::UEF_FS_IDLE && out_load && !cts_block) begin
      ser_valid <= 1'b1;
      // pair two for code 01 and as the second of a dual send  see RULE_12 see RULE_16
      if (fs_q == uef_pkg::UEF_FS_SECOND || efr_q.tx_sw == `UEF_SW_PAIR2) begin
        ser_data <= send_pause_q ? chars_q.pause_char_two : chars_q.resume_char_two;
      end else begin
        ser_data <= send_pause_q ? chars_q.pause_char_one : chars_q.resume_char_one;
      end
    end else if (tx_valid && tx_ready) begin
      ser_valid <= 1'b1;
      ser_data  <= tx_data;
    end else if (ser_ready) begin
      ser_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_cts_stop;
    @(posedge sys_clk) disable iff (!nrst)
    efr_q.auto_cts && cts_in |-> !tx_ready ##1 (fs_q == $past(fs_q) || $past(fs_q) == uef_pkg::UEF_FS_IDLE);
  endproperty
  a_cts_stop: assert property (p_cts_stop) else $error("sending while cts high"); // see RULE_01

  property p_cts_resume;
    @(posedge sys_clk) disable iff (!nrst)
    efr_q.auto_cts && !cts_in && !ser_valid && !remote_paused_q && fs_q == uef_pkg::UEF_FS_IDLE
      && !flow_start |-> tx_ready;
  endproperty
  a_cts_resume: assert property (p_cts_resume) else $error("no resume after cts low"); // see RULE_02

  property p_trig_irq;
    @(posedge sys_clk) disable iff (!nrst)
    efr_q.auto_rts && at_trig && !trig_q |=> status_q[`UEF_EV_TRIG];
  endproperty
  a_trig_irq: assert property (p_trig_irq) else $error("trigger event lost"); // see RULE_03

  property p_rts_high;
    @(posedge sys_clk) disable iff (!nrst)
    efr_q.auto_rts && above_trig ##1 efr_q.auto_rts |-> rts_out;
  endproperty
  a_rts_high: assert property (p_rts_high) else $error("rts not raised above trigger"); // see RULE_04

  property p_rts_low;
    @(posedge sys_clk) disable iff (!nrst)
    efr_q.auto_rts && below_trig ##1 efr_q.auto_rts |-> !rts_out;
  endproperty
  a_rts_low: assert property (p_rts_low) else $error("rts not dropped below trigger"); // see RULE_05

  property p_rts_manual;
    @(posedge sys_clk) disable iff (!nrst)
    !efr_q.auto_rts |-> rts_out == ctrl_q[`UEF_CTRL_RTS];
  endproperty
  a_rts_manual: assert property (p_rts_manual) else $error("rts not under software"); // see RULE_06

  property p_special;
    @(posedge sys_clk) disable iff (!nrst)
    efr_q.special_det && rx_valid && rx_data == chars_q.pause_char_two |=> status_q[`UEF_EV_SPECIAL];
  endproperty
  a_special: assert property (p_special) else $error("special char flag missing"); // see RULE_07

  property p_enh_lock;
    @(posedge sys_clk) disable iff (!nrst)
    !efr_q.enhanced |=> $stable(enh_q);
  endproperty
  a_enh_lock: assert property (p_enh_lock) else $error("latched field changed"); // see RULE_10

  property p_enh_write;
    @(posedge sys_clk) disable iff (!nrst)
    wr && paddr == `UEF_OFS_ENH && efr_q.enhanced |=> enh_q == $past(pwdata[`UEF_ENH_W-1:0]);
  endproperty
  a_enh_write: assert property (p_enh_write) else $error("enhanced write lost"); // see RULE_11

  property p_pause_halt;
    @(posedge sys_clk) disable iff (!nrst)
    pause_hit && efr_q.rx_sw != `UEF_SW_NONE ##1 !resume_hit && efr_q.rx_sw != `UEF_SW_NONE
      |-> !tx_ready ##1 !tx_ready;
  endproperty
  a_pause_halt: assert property (p_pause_halt) else $error("sending after pause"); // see RULE_18

  property p_second_pair;
    @(posedge sys_clk) disable iff (!nrst)
    fs_q == uef_pkg::UEF_FS_SECOND |-> efr_q.tx_sw == `UEF_SW_BOTH || $past(efr_q.tx_sw) == `UEF_SW_BOTH;
  endproperty
  a_second_pair: assert property (p_second_pair) else $error("dual send in single mode"); // see RULE_15

endmodule

/* uef_top_tb_top.sv */
// bench for uef_top: registers over apb, auto cts and rts, special character, flow characters
// assumes uef_ser_model on the serialiser side and one 10 MHz clock
`include "uef_cfg.svh"

module uef_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic              sys_clk = 1'b0;
  logic              nrst = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic              pready;
  logic              pslverr;
  logic [31:0]       prdata;
  logic              tx_valid = 1'b0;
  logic [7:0]        tx_data = 8'h00;
  logic              tx_ready;
  logic              ser_valid;
  logic [7:0]        ser_data;
  logic              ser_ready;
  logic              rx_valid = 1'b0;
  logic [7:0]        rx_data = 8'h00;
  logic [7:0]        rx_level = 8'h00;
  logic              cts_in = 1'b0;
  logic              rts_out;
  uef_pkg::uef_enh_t enh_fields;
  logic              irq;
  logic              stall = 1'b0;
  logic [31:0]       rd;
  logic              sl;
  int                n_fail = 0;
  int                checks_done = 0;
  int                cyc = 0;

  always #50 sys_clk = ~sys_clk;

  uef_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .ser_valid(ser_valid),
    .ser_data(ser_data), .ser_ready(ser_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_level(rx_level), .cts_in(cts_in), .rts_out(rts_out), .enh_fields(enh_fields), .irq(irq));

  uef_ser_model sm_u (.sys_clk(sys_clk), .nrst(nrst), .ser_valid(ser_valid), .ser_data(ser_data),
    .ser_ready(ser_ready), .stall(stall));

  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // request held until pready seen at an edge; data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd      = prdata;
    sl      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask

  task automatic rx(input logic [7:0] c);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_data  <= c;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    tick(2);
  endtask

  task automatic send(input logic [7:0] c);
    @(posedge sys_clk);
    tx_valid <= 1'b1;
    tx_data  <= c;
    do @(posedge sys_clk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask

  ////////////////////////////////////////
  task automatic t_regs();
    rdchk("efr reset", `UEF_OFS_EFR, 32'h0000_0000);
    apb(1'b1, `UEF_OFS_CHARS, 32'hA5C3_1311);
    rdchk("chars", `UEF_OFS_CHARS, 32'hA5C3_1311);
    rdchk("unmapped", 8'h1C, 32'h0000_0000);
    chk("slverr", sl, 32'h0000_0001);
  endtask

  task automatic t_cts();
    int unsigned n0;
    apb(1'b1, `UEF_OFS_EFR, 32'h0000_0080);
    cts_in <= 1'b1;
    tick(3);
    chk("tx_ready cts high", tx_ready, 32'h0000_0000);
    stall  <= 1'b1;
    cts_in <= 1'b0;
    send(8'h41);
    tick(3);
    chk("ser held", {ser_valid, ser_data}, 32'h0000_0141);
    n0 = sm_u.n_q;
    stall <= 1'b0;
    tick(2);
    chk("ser count", sm_u.n_q, n0 + 1);
    apb(1'b1, `UEF_OFS_EFR, 32'h0000_0000);
  endtask

  task automatic t_rts();
    apb(1'b0, `UEF_OFS_STATUS, 32'h0000_0000);
    apb(1'b1, `UEF_OFS_CTRL, 32'h0000_0400);
    apb(1'b1, `UEF_OFS_MASK, 32'h0000_0001);
    apb(1'b1, `UEF_OFS_EFR, 32'h0000_0040);
    rx_level <= 8'h04;
    tick(3);
    chk("irq trig", irq, 32'h0000_0001);
    chk("rts at trig", rts_out, 32'h0000_0000);
    rdchk("status trig", `UEF_OFS_STATUS, 32'h0000_0001);
    tick(1);
    chk("irq cleared", irq, 32'h0000_0000);
    rx_level <= 8'h05;
    tick(3);
    chk("rts above", rts_out, 32'h0000_0001);
    rx_level <= 8'h03;
    tick(3);
    chk("rts hyst", rts_out, 32'h0000_0001);
    rx_level <= 8'h02;
    tick(3);
    chk("rts below", rts_out, 32'h0000_0000);
    apb(1'b1, `UEF_OFS_EFR, 32'h0000_0000);
    apb(1'b1, `UEF_OFS_CTRL, 32'h0000_0401);
    rx_level <= 8'h00;
    tick(2);
    chk("rts sw on", rts_out, 32'h0000_0001);
    apb(1'b1, `UEF_OFS_CTRL, 32'h0000_0400);
    tick(2);
    chk("rts sw off", rts_out, 32'h0000_0000);
    apb(1'b1, `UEF_OFS_MASK, 32'h0000_0000);
  endtask

  task automatic t_spec();
    apb(1'b0, `UEF_OFS_STATUS, 32'h0000_0000);
    apb(1'b1, `UEF_OFS_MASK, 32'h0000_0010);
    apb(1'b1, `UEF_OFS_EFR, 32'h0000_0020);
    rx(8'hA5);
    chk("irq special", irq, 32'h0000_0001);
    rdchk("status special", `UEF_OFS_STATUS, 32'h0000_0010);
    rx(8'hA4);
    rdchk("lsb differs", `UEF_OFS_STATUS, 32'h0000_0000);
    apb(1'b1, `UEF_OFS_MASK, 32'h0000_0000);
  endtask

  task automatic t_enh();
    apb(1'b1, `UEF_OFS_EFR, 32'h0000_0010);
    apb(1'b1, `UEF_OFS_ENH, 32'h0000_05A5);
    tick(1);
    chk("enh set", enh_fields, 32'h0000_05A5);
    apb(1'b1, `UEF_OFS_EFR, 32'h0000_0000);
    tick(1);
    chk("enh off", enh_fields, 32'h0000_0000);
    apb(1'b1, `UEF_OFS_ENH, 32'h0000_0123);
    apb(1'b1, `UEF_OFS_EFR, 32'h0000_0010);
    tick(1);
    chk("enh restored", enh_fields, 32'h0000_05A5);
    apb(1'b1, `UEF_OFS_EFR, 32'h0000_0000);
  endtask

  // character of no selected pair first (other pair, or 00 in either-pair mode), then pause and resume; then the sequence mode
  task automatic t_rxflow();
    logic [7:0] enhanced_feature_control [3] = '{8'h02, 8'h01, 8'h0B};
    logic [7:0] oth [3] = '{8'hA5, 8'hC3, 8'h00};
    logic [7:0] pau [3] = '{8'hC3, 8'hA5, 8'hA5};
    logic [7:0] res [3] = '{8'h11, 8'h13, 8'h13};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `UEF_OFS_EFR, {24'h00_0000, enhanced_feature_control[i]});
      tick(8);
      rx(oth[i]);
      chk("other pair", tx_ready, 32'h0000_0001);
      rx(pau[i]);
      chk("paused", tx_ready, 32'h0000_0000);
      rx(res[i]);
      chk("resumed", tx_ready, 32'h0000_0001);
    end
    apb(1'b1, `UEF_OFS_EFR, 32'h0000_000F);
    tick(8);
    rx(8'hC3);
    rx(8'h00);
    chk("broken sequence", tx_ready, 32'h0000_0001);
    rx(8'hC3);
    rx(8'hA5);
    chk("seq paused", tx_ready, 32'h0000_0000);
    rx(8'h11);
    rx(8'h13);
    chk("seq resumed", tx_ready, 32'h0000_0001);
  endtask

  task automatic t_txflow();
    logic [7:0]  enhanced_feature_control [4] = '{8'h08, 8'h04, 8'h0C, 8'h00};
    logic [7:0]  pau [4] = '{8'hC3, 8'hA5, 8'hC3, 8'h00};
    logic [7:0]  res [4] = '{8'h11, 8'h13, 8'h11, 8'h00};
    int unsigned nc [4] = '{1, 1, 2, 0};
    int unsigned n0;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `UEF_OFS_EFR, {24'h00_0000, enhanced_feature_control[i]});
      tick(8);
      n0 = sm_u.n_q;
      rx_level <= 8'h05;
      tick(10);
      chk("pause count", sm_u.n_q, n0 + nc[i]);
      if (nc[i] > 0) chk("pause char", sm_u.log_q[n0[5:0]], pau[i]);
      if (nc[i] > 1) chk("pause two", sm_u.log_q[n0[5:0] + 6'h01], 8'hA5);
      n0 = sm_u.n_q;
      rx_level <= 8'h00;
      tick(10);
      chk("resume count", sm_u.n_q, n0 + nc[i]);
      if (nc[i] > 0) chk("resume char", sm_u.log_q[n0[5:0]], res[i]);
      if (nc[i] > 1) chk("resume two", sm_u.log_q[n0[5:0] + 6'h01], 8'h13);
    end
  endtask

  ////////////////////////////////////////
  // hang guard; the whole run needs well under this
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    tick(6);
    nrst <= 1'b1;
    t_regs();
    t_cts();
    t_rts();
    t_spec();
    t_enh();
    t_rxflow();
    t_txflow();
    end_of_test();
  end
endmodule
